// ===== src/ep0_std_pkg.sv
/*
 Shared constants and carriers for the endpoint-0 status/feature responder.
 Assumes one 250 MHz clock domain and a synchronous active-low reset.
*/
package ep0_std_pkg;
    localparam logic [7:0] REQ_GET_STATUS = 8'h00;
    localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
    localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
    localparam logic [1:0] RCP_DEVICE = 2'h0;
    localparam logic [1:0] RCP_INTERFACE = 2'h1;
    localparam logic [1:0] RCP_ENDPOINT = 2'h2;
    localparam logic [15:0] FSEL_ENDPOINT_HALT = 16'h0000;
    localparam logic [15:0] FSEL_REMOTE_WAKEUP = 16'h0001;
    localparam logic [3:0] CMD_ENDPOINT_STALL_COMMAND = 4'h4;
    localparam logic [3:0] CMD_EP_CLEAR = 4'h3;
    localparam logic [3:0] EP_ZERO = 4'h0;
    localparam int NUM_EP = 16;
    localparam int DEV_WAKE_BIT = 1;
    localparam int DEV_SELF_BIT = 0;
    localparam int EP_HALT_BIT = 0;
    // AXI4-Lite register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EP_EXIST = 8'h08;
    localparam logic [7:0] ADDR_IF_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_EP_HALT = 8'h10;
    localparam logic [31:0] RST_EP_EXIST = 32'h0000_0001;
    localparam logic [31:0] RST_IF_COUNT = 32'h0000_0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        DST_DEFAULT = 2'b00,
        DST_ADDRESS = 2'b01,
        DST_CONFIGURED = 2'b10
    } dev_state_e;

    typedef struct packed {
        logic [7:0] req_type;
        logic [7:0] request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } setup_s;

    typedef struct packed {
        logic [3:0] ep;
        logic [3:0] com;
    } ctl_cmd_s;
endpackage

// ===== src/ep0_status_word_ram.sv
/*
 Small halt-flag memory, one bit per endpoint, read data registered.
 Assumes the caller serialises writes; a write and a read to one slot
 in the same cycle return the old value.
*/
`timescale 1ns/1ps
module ep0_status_word_ram (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic i_wdata,
    input wire logic [3:0] i_raddr,
    output logic o_rdata,
    output logic [15:0] o_all
);
    logic [15:0] mem_ff;
    logic rdata_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mem_ff <= 16'h0000;
        end else if (i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_ff <= 1'b0;
        end else begin
            rdata_ff <= mem_ff[i_raddr];
        end
    end

    assign o_rdata = rdata_ff;
    assign o_all = mem_ff;
endmodule

// ===== src/usb_ep0_status_feature_responder.sv
/*
 Decodes GET_STATUS, CLEAR_FEATURE and SET_FEATURE setups on endpoint 0 and
 answers with a FIFO status word, an endpoint clear, wakeup/halt bookkeeping
 or an endpoint-0 stall command. Assumes the setup stage sequencer presents
 one decoded setup packet per i_setup_valid pulse and forwards the command
 and FIFO byte strobes to the controller core. Registers over AXI4-Lite.
*/
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
// Contract
// - Missing interface or endpoint stalls endpoint zero
// - Address state status query answer selection
// - Configured state returns device, interface, endpoint word
// - Device word carries wakeup and self-powered
// - Interface status word is all zero
// - Endpoint word bit zero shows halt; the halt memory is only written with zero, so it reads 0
// - Unknown or uncleareable selector stalls endpoint zero
// - Clear selector one disables remote wakeup
// - Address state nonzero endpoint clear stalls
// - Clear halt on endpoint zero is bookkeeping
// - Configured clear halt resets nonzero endpoint
// - Interface feature requests stall endpoint zero
// - Unknown or unsettable selector stalls endpoint zero
// - Set recipient from index low byte
// - Configured set selector one enables wakeup
// - Address state set halt marks endpoint zero
// - Halted endpoint zero stalls later requests
// - Setup token lifts endpoint zero stall
// - Stall command is endpoint 0, code 4
`timescale 1ns/1ps
module usb_ep0_status_feature_responder (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_setup_valid,
    input wire ep0_std_pkg::setup_s i_setup,
    input wire ep0_std_pkg::dev_state_e i_dev_state,
    input wire logic i_self_powered,
    input wire logic i_fifo_ready,
    output logic o_fifo_wr,
    output logic [7:0] o_fifo_data,
    output logic o_fifo_eop,
    output logic o_cmd_valid,
    output ep0_std_pkg::ctl_cmd_s o_cmd,
    output logic o_busy,
    output logic o_ep0_halted,
    output logic o_remote_wakeup,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    import ep0_std_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_EOP = 3'b100
    } phase_e;

    phase_e phase_ff;
    ctl_cmd_s cmd_ff;
    logic [15:0] word_ff, halt_all;
    logic [1:0] word_kind_ff, rcp, bresp_ff, rresp_ff;
    logic [7:0] fifo_data_ff, awaddr_ff;
    logic [31:0] ep_exist_ff, if_count_ff, wdata_ff, rdata_ff;
    logic [3:0] stall_cnt_ff, ep_sel, wstrb_ff;
    logic ep0_halt_ff, wake_ff, ctrl_self_ff, halt_rd;
    logic fifo_wr_ff, fifo_eop_ff, cmd_valid_ff;
    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
    logic do_stall, do_send, do_clear_ep, wake_set, wake_clr, halt0_set, halt0_clr;

    function automatic logic ep_exists(input logic [31:0] map, input logic [3:0] ep);
        ep_exists = map[ep];
    endfunction
    function automatic logic if_exists(input logic [31:0] cnt, input logic [15:0] idx);
        if_exists = ({16'h0000, idx} < cnt);
    endfunction

    assign rcp = i_setup.req_type[1:0];
    assign ep_sel = i_setup.index[3:0];
    // Request decode; unhandled requests fall into a stall, except unconfigured wakeup sets and configured halt sets, which are ignored
    always_comb begin
        do_stall = 1'b0;
        do_send = 1'b0;
        do_clear_ep = 1'b0;
        wake_set = 1'b0;
        wake_clr = 1'b0;
        halt0_set = 1'b0;
        halt0_clr = 1'b0;
        if (i_setup_valid && phase_ff == ST_IDLE) begin
            if (ep0_halt_ff || i_dev_state == DST_DEFAULT) begin
                do_stall = 1'b1;
            end else unique case (i_setup.request)
                REQ_GET_STATUS: begin
                    unique case (rcp)
                        RCP_DEVICE: do_send = 1'b1;
                        RCP_INTERFACE: begin
                            do_send = (i_dev_state == DST_CONFIGURED) &&
                                if_exists(if_count_ff, i_setup.index);
                            do_stall = !do_send;
                        end
                        RCP_ENDPOINT: begin
                            do_send = (i_dev_state == DST_CONFIGURED) ?
                                ep_exists(ep_exist_ff, ep_sel) : (ep_sel == EP_ZERO);
                            do_stall = !do_send;
                        end
                        default: do_stall = 1'b1;
                    endcase
                end
                REQ_CLEAR_FEATURE, REQ_SET_FEATURE: begin
                    unique case (rcp)
                        RCP_DEVICE: begin
                            if (i_setup.value != FSEL_REMOTE_WAKEUP) begin
                                do_stall = 1'b1;
                            end else if (i_setup.request == REQ_CLEAR_FEATURE) begin
                                wake_clr = 1'b1;
                            end else if (i_dev_state == DST_CONFIGURED) begin
                                wake_set = 1'b1;
                            end
                        end
                        RCP_INTERFACE: do_stall = 1'b1;
                        RCP_ENDPOINT: begin
                            if (i_setup.value != FSEL_ENDPOINT_HALT) begin
                                do_stall = 1'b1;
                            end else if (i_setup.index[7:0] == 8'h00) begin
                                halt0_clr = (i_setup.request == REQ_CLEAR_FEATURE);
                                halt0_set = (i_setup.request == REQ_SET_FEATURE) &&
                                    (i_dev_state == DST_ADDRESS);
                            end else if (i_dev_state == DST_ADDRESS) begin
                                do_stall = 1'b1;
                            end else if (!ep_exists(ep_exist_ff, ep_sel) ||
                                         i_setup.index[7:4] != 4'h0) begin
                                do_stall = 1'b1;
                            end else if (i_setup.request == REQ_CLEAR_FEATURE) begin
                                do_clear_ep = 1'b1;
                            end
                        end
                        default: do_stall = 1'b1;
                    endcase
                end
                default: do_stall = 1'b1;
            endcase
        end
    end

    ep0_status_word_ram u_halt_ram (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(do_clear_ep),
        .i_waddr(ep_sel),
        .i_wdata(1'b0),
        .i_raddr(ep_sel),
        .o_rdata(halt_rd),
        .o_all(halt_all)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wake_ff <= 1'b0;
        end else if (wake_set || wake_clr) begin
            wake_ff <= wake_set;
        end
    end

    // A fresh setup does not lift the bookkeeping halt; only reset does, as a halted endpoint zero stalls clear-halt too
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ep0_halt_ff <= 1'b0;
        end else if (halt0_set || halt0_clr) begin
            ep0_halt_ff <= halt0_set;
        end
    end

    // Status word build and byte serialiser
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_ff <= ST_IDLE;
            word_kind_ff <= RCP_DEVICE;
            word_ff <= 16'h0000;
        end else begin
            unique case (phase_ff)
                ST_IDLE: begin
                    if (do_send) begin
                        phase_ff <= ST_READ;
                        word_kind_ff <= rcp;
                    end
                end
                ST_READ: begin
                    word_ff <= 16'h0000;
                    if (word_kind_ff == RCP_DEVICE) begin
                        word_ff[DEV_WAKE_BIT] <= wake_ff;
                        word_ff[DEV_SELF_BIT] <= i_self_powered | ctrl_self_ff;
                    end else if (word_kind_ff == RCP_ENDPOINT) begin
                        word_ff[EP_HALT_BIT] <= halt_rd;
                    end
                    phase_ff <= ST_LOW;
                end
                ST_LOW: if (i_fifo_ready) phase_ff <= ST_HIGH;
                ST_HIGH: if (i_fifo_ready) phase_ff <= ST_EOP;
                ST_EOP: if (i_fifo_ready) phase_ff <= ST_IDLE;
                default: phase_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fifo_wr_ff <= 1'b0;
            fifo_data_ff <= 8'h00;
            fifo_eop_ff <= 1'b0;
        end else begin
            fifo_wr_ff <= i_fifo_ready && (phase_ff == ST_LOW || phase_ff == ST_HIGH);
            fifo_data_ff <= (phase_ff == ST_HIGH) ? word_ff[15:8] : word_ff[7:0];
            fifo_eop_ff <= i_fifo_ready && phase_ff == ST_EOP;
        end
    end

    // Controller command strobe; the core itself lifts the stall on SETUP
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cmd_valid_ff <= 1'b0;
            cmd_ff <= '0;
            stall_cnt_ff <= 4'h0;
        end else begin
            cmd_valid_ff <= do_stall || do_clear_ep;
            if (do_stall) begin
                cmd_ff <= '{ep: EP_ZERO, com: CMD_ENDPOINT_STALL_COMMAND};
                stall_cnt_ff <= stall_cnt_ff + 4'h1;
            end else if (do_clear_ep) begin
                cmd_ff <= '{ep: ep_sel, com: CMD_EP_CLEAR};
            end
        end
    end

    // AXI4-Lite write channel: address and data accepted in either order
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            ctrl_self_ff <= 1'b0;
            ep_exist_ff <= RST_EP_EXIST;
            if_count_ff <= RST_IF_COUNT;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (aw_held_ff && w_held_ff && !bvalid_ff) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= RESP_OKAY;
                unique case (awaddr_ff)
                    ADDR_CTRL: if (wstrb_ff[0]) ctrl_self_ff <= wdata_ff[0];
                    ADDR_EP_EXIST: begin
                        for (int b = 0; b < 4; b++) begin
                            if (wstrb_ff[b]) ep_exist_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
                        end
                        ep_exist_ff[0] <= 1'b1;
                    end
                    ADDR_IF_COUNT: begin
                        for (int b = 0; b < 4; b++) begin
                            if (wstrb_ff[b]) if_count_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
                        end
                    end
                    ADDR_STATUS, ADDR_EP_HALT: bresp_ff <= RESP_OKAY;
                    default: bresp_ff <= RESP_DECERR;
                endcase
            end else if (bvalid_ff && i_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            unique case (i_araddr)
                ADDR_CTRL: rdata_ff <= {31'h0000_0000, ctrl_self_ff};
                ADDR_STATUS: rdata_ff <= {24'h00_0000, stall_cnt_ff, 1'b0,
                    (phase_ff != ST_IDLE), wake_ff, ep0_halt_ff};
                ADDR_EP_EXIST: rdata_ff <= ep_exist_ff;
                ADDR_IF_COUNT: rdata_ff <= if_count_ff;
                ADDR_EP_HALT: rdata_ff <= {16'h0000, halt_all};
                default: rresp_ff <= RESP_DECERR;
            endcase
        end else if (rvalid_ff && i_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign o_awready = !aw_held_ff && !bvalid_ff;
    assign o_wready = !w_held_ff && !bvalid_ff;
    assign o_arready = !rvalid_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;
    assign o_fifo_wr = fifo_wr_ff;
    assign o_fifo_data = fifo_data_ff;
    assign o_fifo_eop = fifo_eop_ff;
    assign o_cmd_valid = cmd_valid_ff;
    assign o_cmd = cmd_ff;
    assign o_busy = (phase_ff != ST_IDLE);
    assign o_ep0_halted = ep0_halt_ff;
    assign o_remote_wakeup = wake_ff;

    a_stall_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        do_stall |=> cmd_valid_ff && cmd_ff.ep == EP_ZERO && cmd_ff.com == CMD_ENDPOINT_STALL_COMMAND)
        else $error("stall command not issued");
    a_halt_stall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_setup_valid && phase_ff == ST_IDLE && ep0_halt_ff) |=> cmd_valid_ff && !fifo_wr_ff)
        else $error("halted endpoint zero not stalled");
    a_iface_feat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_setup_valid && phase_ff == ST_IDLE && rcp == RCP_INTERFACE &&
         i_setup.request != REQ_GET_STATUS) |-> do_stall)
        else $error("interface feature request not stalled");
    a_wake_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wake_set |=> wake_ff) else $error("remote wakeup not enabled");
    a_wake_clr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wake_clr |=> !wake_ff) else $error("remote wakeup not disabled");
    a_low_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (phase_ff == ST_LOW && i_fifo_ready) |=> fifo_wr_ff && fifo_data_ff == word_ff[7:0])
        else $error("low byte not written first");
    a_clear_ep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        do_clear_ep |=> cmd_valid_ff && cmd_ff.com == CMD_EP_CLEAR && cmd_ff.ep != EP_ZERO)
        else $error("endpoint clear not issued");
    a_addr_ep_get: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_setup_valid && phase_ff == ST_IDLE && !ep0_halt_ff && i_dev_state == DST_ADDRESS
         && i_setup.request == REQ_GET_STATUS && rcp == RCP_ENDPOINT && ep_sel != EP_ZERO)
        |-> do_stall) else $error("address state endpoint query not stalled");
    a_word_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (phase_ff == ST_READ) |=> phase_ff == ST_LOW) else $error("status word not built");
endmodule

// ===== test/usb_host_ep0_model.sv
/*
 Host-side model of endpoint 0: accepts status bytes and controller commands.
 Assumes one shared clock and the responder's one-cycle strobes.
*/
`timescale 1ns/1ps
module usb_host_ep0_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic i_fifo_wr,
    input wire logic [7:0] i_fifo_data,
    input wire logic i_fifo_eop,
    input wire logic i_cmd_valid,
    input wire ep0_std_pkg::ctl_cmd_s i_cmd,
    output logic o_fifo_ready,
    output logic [7:0] o_ncmd,
    output ep0_std_pkg::ctl_cmd_s o_last_cmd,
    output logic [7:0] o_nword,
    output logic [15:0] o_word
);
    import ep0_std_pkg::*;
    logic tick_ff;
    logic hi_ff;
    // Slow mode refuses every other cycle so the data stage must wait
    assign o_fifo_ready = !i_slow || tick_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tick_ff <= 1'b0;
            hi_ff <= 1'b0;
            o_ncmd <= 8'h00;
            o_nword <= 8'h00;
            o_word <= 16'h0000;
            o_last_cmd <= 8'h00;
        end else begin
            tick_ff <= !tick_ff;
            if (i_cmd_valid) begin
                o_ncmd <= o_ncmd + 8'h01;
                o_last_cmd <= i_cmd;
            end
            // Low byte lands first, high byte second
            if (i_fifo_wr) begin
                hi_ff <= !hi_ff;
                if (hi_ff) o_word[15:8] <= i_fifo_data;
                else o_word[7:0] <= i_fifo_data;
            end
            if (i_fifo_eop) begin
                o_nword <= o_nword + 8'h01;
            end
        end
    end
endmodule

// ===== test/usb_ep0_status_feature_responder_test.sv
/*
 Self-checking bench: setup requests and AXI4-Lite accesses with expected answers.
 Assumes the host model in usb_host_ep0_model and a 250 MHz clock.
*/
`timescale 1ns/1ps
module usb_ep0_status_feature_responder_test;
    import ep0_std_pkg::*;
    localparam logic [7:0] STL = 8'h04;
    logic i_clk, i_rst_n, i_setup_valid, i_self_powered, slow, i_fifo_ready;
    setup_s i_setup;
    dev_state_e i_dev_state;
    logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [7:0] i_awaddr, i_araddr, o_fifo_data, ncmd, nword;
    logic [31:0] i_wdata, o_rdata, d;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, r;
    logic o_fifo_wr, o_fifo_eop, o_cmd_valid, o_busy, o_ep0_halted, o_remote_wakeup;
    ctl_cmd_s o_cmd, last_cmd;
    logic [15:0] word;
    int bad_count = 0;
    int total_checks = 0;
    usb_ep0_status_feature_responder DUT (.i_clk, .i_rst_n, .i_setup_valid, .i_setup,
        .i_dev_state, .i_self_powered, .i_fifo_ready, .o_fifo_wr, .o_fifo_data, .o_fifo_eop,
        .o_cmd_valid, .o_cmd, .o_busy, .o_ep0_halted, .o_remote_wakeup, .i_awvalid,
        .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
        .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);
    usb_host_ep0_model host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
        .i_fifo_wr(o_fifo_wr), .i_fifo_data(o_fifo_data), .i_fifo_eop(o_fifo_eop),
        .i_cmd_valid(o_cmd_valid), .i_cmd(o_cmd), .o_fifo_ready(i_fifo_ready),
        .o_ncmd(ncmd), .o_last_cmd(last_cmd), .o_nword(nword), .o_word(word));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Ready is sampled in the low phase, so it is the value the next edge sees
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge i_clk);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= v;
        while (!(aw && w)) begin
            @(negedge i_clk);
            if (i_awvalid && o_awready) aw = 1'b1;
            if (i_wvalid && o_wready) w = 1'b1;
            @(posedge i_clk);
            if (aw) i_awvalid <= 1'b0;
            if (w) i_wvalid <= 1'b0;
        end
        i_bready <= 1'b1;
        do begin
            @(negedge i_clk);
            aw = o_bvalid;
            r = o_bresp;
            @(posedge i_clk);
        end while (!aw);
        i_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        logic got;
        @(posedge i_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        do begin
            @(negedge i_clk);
            got = o_arready;
            @(posedge i_clk);
        end while (!got);
        i_arvalid <= 1'b0;
        i_rready <= 1'b1;
        do begin
            @(negedge i_clk);
            got = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_clk);
        end while (!got);
        i_rready <= 1'b0;
    endtask
    // kind: 0 no answer, 1 controller command, 2 status word
    task automatic req(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v,
            input logic [15:0] ix, input int kind, input logic [15:0] exp);
        logic [7:0] nc, nw;
        nc = ncmd;
        nw = nword;
        @(negedge i_clk);
        while (o_busy) @(negedge i_clk);
        @(posedge i_clk);
        i_setup_valid <= 1'b1;
        // Status queries ask for two bytes, feature requests for none
        i_setup <= setup_s'{rt, rq, v, ix, (rq == REQ_GET_STATUS) ? 16'h0002 : 16'h0000};
        @(posedge i_clk);
        i_setup_valid <= 1'b0;
        repeat (3) @(negedge i_clk);
        while (o_busy) @(negedge i_clk);
        repeat (2) @(negedge i_clk);
        chk("commands", ncmd, nc + ((kind == 1) ? 8'h01 : 8'h00));
        chk("words", nword, nw + ((kind == 2) ? 8'h01 : 8'h00));
        if (kind == 1) chk("command", last_cmd, exp[7:0]);
        if (kind == 2) chk("word", word, exp);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = !i_clk;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        {i_rst_n, i_setup_valid, i_self_powered, slow, i_awvalid, i_wvalid} = 6'h00;
        {i_bready, i_arvalid, i_rready} = 3'h0;
        {i_awaddr, i_araddr, i_wdata} = 48'h0;
        i_wstrb = 4'hF;
        i_setup = '0;
        i_dev_state = DST_DEFAULT;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        axr(ADDR_EP_EXIST);
        chk("ep_exist", d, RST_EP_EXIST);
        axr(ADDR_IF_COUNT);
        chk("if_count", d, RST_IF_COUNT);
        axr(8'h40);
        chk("rresp", r, RESP_DECERR);
        axw(ADDR_CTRL, 32'h0000_0001);
        axw(ADDR_EP_EXIST, 32'h0000_0005);
        axw(ADDR_IF_COUNT, 32'h0000_0002);
        chk("bresp", r, RESP_OKAY);
        req(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 1, STL);
        @(posedge i_clk);
        i_dev_state <= DST_ADDRESS;
        req(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 2, 16'h0001);
        req(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0000, 1, STL);
        req(8'h82, REQ_GET_STATUS, 16'h0000, 16'h0000, 2, 16'h0000);
        req(8'h82, REQ_GET_STATUS, 16'h0000, 16'h0002, 1, STL);
        req(8'h80, REQ_CLEAR_FEATURE, 16'h0001, 16'h0000, 0, 16'h0000);
        req(8'h80, REQ_CLEAR_FEATURE, 16'h0005, 16'h0000, 1, STL);
        req(8'h81, REQ_CLEAR_FEATURE, 16'h0000, 16'h0000, 1, STL);
        req(8'h82, REQ_CLEAR_FEATURE, 16'h0000, 16'h0002, 1, STL);
        req(8'h82, REQ_CLEAR_FEATURE, 16'h0000, 16'h0000, 0, 16'h0000);
        @(posedge i_clk);
        i_dev_state <= DST_CONFIGURED;
        slow <= 1'b1;
        req(8'h80, REQ_SET_FEATURE, 16'h0001, 16'h0000, 0, 16'h0000);
        chk("wakeup", o_remote_wakeup, 32'h1);
        req(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 2, 16'h0003);
        req(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0001, 2, 16'h0000);
        req(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0002, 1, STL);
        req(8'h82, REQ_GET_STATUS, 16'h0000, 16'h0002, 2, 16'h0000);
        req(8'h82, REQ_GET_STATUS, 16'h0000, 16'h0003, 1, STL);
        req(8'h82, REQ_CLEAR_FEATURE, 16'h0000, 16'h0002, 1, {4'h2, CMD_EP_CLEAR});
        req(8'h82, REQ_CLEAR_FEATURE, 16'h0000, 16'h0003, 1, STL);
        req(8'h80, REQ_CLEAR_FEATURE, 16'h0001, 16'h0000, 0, 16'h0000);
        chk("wakeup", o_remote_wakeup, 32'h0);
        req(8'h80, REQ_SET_FEATURE, 16'h0009, 16'h0000, 1, STL);
        req(8'h81, REQ_SET_FEATURE, 16'h0000, 16'h0000, 1, STL);
        req(8'h82, REQ_SET_FEATURE, 16'h0000, 16'h0007, 1, STL);
        @(posedge i_clk);
        i_dev_state <= DST_ADDRESS;
        slow <= 1'b0;
        req(8'h82, REQ_SET_FEATURE, 16'h0000, 16'h0002, 1, STL);
        req(8'h82, REQ_SET_FEATURE, 16'h0000, 16'h0100, 0, 16'h0000);
        chk("ep0_halt", o_ep0_halted, 32'h1);
        req(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 1, STL);
        req(8'h82, REQ_CLEAR_FEATURE, 16'h0000, 16'h0000, 1, STL);
        // Fifteen stalls so far, endpoint zero halted, wakeup off, idle
        axr(ADDR_STATUS);
        chk("status", d, 32'h0000_00F1);
        axw(8'h40, 32'h0000_0000);
        chk("bresp", r, RESP_DECERR);
        complete_run();
    end
endmodule
